/* File: common/sync_fifo_prog_flags_defines.vh */
// Constants for the nine-bit synchronous FIFO with programmable flags.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef SYNC_FIFO_PROG_FLAGS_DEFINES_VH
`define SYNC_FIFO_PROG_FLAGS_DEFINES_VH

// ****************************************************************
// Geometry
// ****************************************************************
`define FIFO_DEPTH          64
`define FIFO_WIDTH          9
`define OFFSET_WIDTH        8

// ****************************************************************
// Offset register sequence positions
// ****************************************************************
`define OFS_EMPTY_LOW       2'h0
`define OFS_EMPTY_HIGH      2'h1
`define OFS_FULL_LOW        2'h2
`define OFS_FULL_HIGH       2'h3

// ****************************************************************
// Reset values
// ****************************************************************
`define EMPTY_LOW_RESET     8'h07
`define EMPTY_HIGH_RESET    8'h00
`define FULL_LOW_RESET      8'h07
`define FULL_HIGH_RESET     8'h00

// ****************************************************************
// Mode latched at reset
// ****************************************************************
`define MODE_PROG_FLAGS     1'b0
`define MODE_DUAL_ENABLE    1'b1

`endif

/* File: src/sync_fifo_prog_flags.v */
// Synchronous FIFO control with memory, programmable flags and output buffer.
// Assumes one clock serves as both write and read clock; inputs are synchronous.
`timescale 1ns/1ps
`include "sync_fifo_prog_flags_defines.vh"

module sync_fifo_prog_flags #(
  parameter DEPTH = `FIFO_DEPTH,
  parameter WIDTH = `FIFO_WIDTH
) (
  input  wire             i_clk_sys,
  input  wire             i_reset,
  input  wire [WIDTH-1:0] i_data,
  input  wire             i_write_enable_primary_n,
  input  wire             i_write_enable_secondary_or_load,
  input  wire             i_read_enable_a_n,
  input  wire             i_read_enable_b_n,
  input  wire             i_rd_ready,
  output wire [WIDTH-1:0] o_rd_data,
  output wire             o_rd_valid,
  output wire             o_empty_flag_n,
  output wire             o_almost_empty_flag_n,
  output wire             o_almost_full_flag_n,
  output wire             o_full_flag_n,
  output wire             o_dual_enable_mode
);

  localparam AW = $clog2(DEPTH);
  localparam OW = `OFFSET_WIDTH;
  localparam [AW:0] DEPTH_C = DEPTH[AW:0];

  // ****************************************************************
  // Usage notes
  // ****************************************************************
  // One clock serves as write and read clock, so the flag
  // update edges of the two sides coincide.
  // Pointers wrap by overflow: DEPTH must be a power of two.
  // Only the low log2(DEPTH) offset bits set a threshold, so an
  // offset of DEPTH or more aliases to a small one.
  // An offset read needs a free skid slot; a stalled receiver
  // holds the offset sequence where it is.
  // A colliding offset write and read keeps the write and
  // drops the read; the sequence steps once.
  // FIFO reads pause while the load pin is low in flag mode.
  // Words and offsets share one two-entry buffer, so they
  // leave in the order they were taken.
  // Thresholds follow offset loads from the next edge on.

  // ****************************************************************
  // State
  // ****************************************************************
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wptr_q;
  reg [AW-1:0]    rptr_q;
  reg [AW:0]      count_q;
  reg             mode_q;
  reg [1:0]       seq_q;
  reg             empty_n_q;
  reg             almost_empty_n_q;
  reg             almost_full_n_q;
  reg             full_n_q;
  reg [WIDTH-1:0] out_q;
  reg             out_v_q;
  reg [WIDTH-1:0] skid_q;
  reg             skid_v_q;
  wire [4*OW-1:0] ofs_flat;
  reg [1:0]       seq_d;
  reg             empty_n_d;
  reg             almost_empty_n_d;
  reg             almost_full_n_d;
  reg             full_n_d;
  reg [WIDTH-1:0] out_d;
  reg             out_v_d;
  reg [WIDTH-1:0] skid_d;
  reg             skid_v_d;

  // ****************************************************************
  // Request decode
  // ****************************************************************
  wire load_n    = i_write_enable_secondary_or_load;
  wire wen_act   = ~i_write_enable_primary_n;
  wire ren_act   = ~i_read_enable_a_n & ~i_read_enable_b_n;
  wire prog_mode = (mode_q == `MODE_PROG_FLAGS);
  // Skid slot free means a read can always be caught
  wire buf_room  = ~skid_v_q;

  wire ofs_access = prog_mode & ~load_n;
  // offset load on load and primary low
  wire ofs_wr = ofs_access & wen_act;
  // offset read; write wins if host collides
  wire ofs_rd = ofs_access & ren_act & ~ofs_wr & buf_room;

  // load high with primary low writes FIFO
  wire fifo_wr = wen_act & load_n & full_n_q;
  wire fifo_rd = ren_act & ~ofs_access & empty_n_q & buf_room;

  // ****************************************************************
  // Offset registers
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ofs
      reg [OW-1:0] val_q;
      always @(posedge i_clk_sys) begin
        if (i_reset) begin
          case (g)
            0:       val_q <= `EMPTY_LOW_RESET;
            1:       val_q <= `EMPTY_HIGH_RESET;
            2:       val_q <= `FULL_LOW_RESET;
            default: val_q <= `FULL_HIGH_RESET;
          endcase
        end else if (ofs_wr && seq_q == g) begin
          val_q <= i_data[OW-1:0];
        end
      end
      assign ofs_flat[g*OW +: OW] = val_q;
    end
  endgenerate

  // n and m from high above low
  wire [2*OW-1:0] n_full = {ofs_flat[`OFS_EMPTY_HIGH*OW +: OW], ofs_flat[`OFS_EMPTY_LOW*OW +: OW]};
  wire [2*OW-1:0] m_full = {ofs_flat[`OFS_FULL_HIGH*OW +: OW], ofs_flat[`OFS_FULL_LOW*OW +: OW]};
  wire [AW:0] n_th = {1'b0, n_full[AW-1:0]};
  wire [AW:0] m_th = {1'b0, m_full[AW-1:0]};
  wire [AW:0] af_level = DEPTH_C - m_th;

  wire [OW-1:0] ofs_sel = ofs_flat[seq_q*OW +: OW];
  wire [WIDTH-1:0] push_data = ofs_rd ? {{(WIDTH-OW){1'b0}}, ofs_sel} : mem[rptr_q];
  wire push = ofs_rd | fifo_rd;

  // ****************************************************************
  // Mode and sequence
  // ****************************************************************
  always @* begin
    seq_d = seq_q;
    if (ofs_wr || ofs_rd) begin
      // two-bit sequence wraps to empty low
      seq_d = seq_q + 2'h1;
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      // mode caught while reset is held
      mode_q <= i_write_enable_secondary_or_load;
      seq_q  <= `OFS_EMPTY_LOW;
    end else begin
      seq_q  <= seq_d;
    end
  end

  // ****************************************************************
  // Pointers, count and memory
  // ****************************************************************
  wire [AW:0] count_d = count_q + {{AW{1'b0}}, fifo_wr} - {{AW{1'b0}}, fifo_rd};

  always @(posedge i_clk_sys) begin
    if (fifo_wr) begin
      mem[wptr_q] <= i_data;
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      wptr_q  <= {AW{1'b0}};
      rptr_q  <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (fifo_wr) begin
        wptr_q <= wptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (fifo_rd) begin
        rptr_q <= rptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      count_q <= count_d;
    end
  end

  // ****************************************************************
  // Flags
  // ****************************************************************
  // Registered from next count so they track the edge that moved it
  always @* begin
    empty_n_d        = (count_d != {(AW+1){1'b0}});
    almost_empty_n_d = (count_d > n_th);
    almost_full_n_d  = (count_d < af_level);
    full_n_d         = (count_d != DEPTH_C);
  end

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      empty_n_q        <= 1'b0;
      almost_empty_n_q <= 1'b0;
      almost_full_n_q  <= 1'b1;
      full_n_q         <= 1'b1;
    end else begin
      empty_n_q        <= empty_n_d;
      almost_empty_n_q <= almost_empty_n_d;
      almost_full_n_q  <= almost_full_n_d;
      full_n_q         <= full_n_d;
    end
  end

  // ****************************************************************
  // Two-entry output buffer
  // ****************************************************************
  // Reads stall once the skid slot holds a word, so nothing is lost
  wire drain = ~out_v_q | i_rd_ready;

  // next word or offset enters the buffer
  always @* begin
    out_d    = out_q;
    out_v_d  = out_v_q;
    skid_d   = skid_q;
    skid_v_d = skid_v_q;
    if (drain) begin
      if (skid_v_q) begin
        out_d    = skid_q;
        out_v_d  = 1'b1;
        skid_v_d = 1'b0;
      end else begin
        out_v_d = push;
        if (push) begin
          out_d = push_data;
        end
      end
    end else if (push) begin
      skid_d   = push_data;
      skid_v_d = 1'b1;
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      out_q    <= {WIDTH{1'b0}};
      out_v_q  <= 1'b0;
      skid_q   <= {WIDTH{1'b0}};
      skid_v_q <= 1'b0;
    end else begin
      out_q    <= out_d;
      out_v_q  <= out_v_d;
      skid_q   <= skid_d;
      skid_v_q <= skid_v_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_rd_data             = out_q;
  assign o_rd_valid            = out_v_q;
  assign o_empty_flag_n        = empty_n_q;
  assign o_almost_empty_flag_n = almost_empty_n_q;
  assign o_almost_full_flag_n  = almost_full_n_q;
  assign o_full_flag_n         = full_n_q;
  assign o_dual_enable_mode    = mode_q;

endmodule

/* File: dv/fifo_props.sv */
// Port checker for the programmable-flag FIFO.
// Assumes it is bound into the design top; one clock, synchronous reset.
`timescale 1ns/1ps
module fifo_props #(parameter WIDTH = 9) (
  input wire             i_clk_sys,
  input wire             i_reset,
  input wire             i_write_enable_primary_n,
  input wire             i_write_enable_secondary_or_load,
  input wire             i_read_enable_a_n,
  input wire             i_read_enable_b_n,
  input wire             i_rd_ready,
  input wire [WIDTH-1:0] o_rd_data,
  input wire             o_rd_valid,
  input wire             o_empty_flag_n,
  input wire             o_almost_empty_flag_n,
  input wire             o_almost_full_flag_n,
  input wire             o_full_flag_n,
  input wire             o_dual_enable_mode
);
  wire rd  = !i_read_enable_a_n && !i_read_enable_b_n;
  wire wr  = !i_write_enable_primary_n && i_write_enable_secondary_or_load;
  // Load low in flag mode turns reads into offset reads
  wire nrm = o_dual_enable_mode || i_write_enable_secondary_or_load;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  a_reset_flags: assert property ($past(i_reset) |-> !o_empty_flag_n && o_full_flag_n && !o_rd_valid)
    else $error("flags wrong after reset");
  a_mode_latch: assert property ($past(i_reset) |-> o_dual_enable_mode == $past(i_write_enable_secondary_or_load))
    else $error("mode not taken from pin at reset");
  a_empty_almost: assert property (!o_empty_flag_n |-> !o_almost_empty_flag_n)
    else $error("almost empty high while empty");
  a_full_almost: assert property (!o_full_flag_n |-> !o_almost_full_flag_n)
    else $error("almost full high while full");
  a_full_blocks: assert property (!o_full_flag_n && !rd |=> !o_full_flag_n)
    else $error("write taken while full");
  a_empty_fills: assert property (!o_empty_flag_n && wr |=> o_empty_flag_n)
    else $error("write into empty fifo lost");
  a_empty_blocks: assert property (!o_empty_flag_n && !o_rd_valid && nrm |=> !o_rd_valid)
    else $error("read taken while empty");
  a_read_answer: assert property (o_empty_flag_n && !o_rd_valid && rd && nrm |=> o_rd_valid)
    else $error("read word not presented");
  a_hold_word: assert property (o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable(o_rd_data))
    else $error("word dropped during stall");
  c_full: cover property (!o_full_flag_n);
  c_ae_rise: cover property ($rose(o_almost_empty_flag_n));
  c_stall: cover property (o_rd_valid && !i_rd_ready);
endmodule
bind sync_fifo_prog_flags fifo_props #(.WIDTH(WIDTH)) u_props (.i_clk_sys, .i_reset,
  .i_write_enable_primary_n, .i_write_enable_secondary_or_load, .i_read_enable_a_n, .i_read_enable_b_n,
  .i_rd_ready, .o_rd_data, .o_rd_valid, .o_empty_flag_n, .o_almost_empty_flag_n, .o_almost_full_flag_n,
  .o_full_flag_n, .o_dual_enable_mode);

/* File: dv/rd_sink.sv */
// Receiver model behind the FIFO output buffer.
// Assumes the bench sets i_stall by non-blocking assignment.
`timescale 1ns/1ps
module rd_sink (
  input  wire       i_clk_sys,
  input  wire       i_stall,
  input  wire       i_valid,
  input  wire [8:0] i_data,
  output reg        o_ready
);
  logic [8:0] q[$];
  initial o_ready = 1'b1;
  // Ready lags stall by one edge, like a registered receiver
  always @(posedge i_clk_sys) begin
    if (i_valid && o_ready) q.push_back(i_data);
    o_ready <= !i_stall;
  end
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the programmable-flag FIFO.
// Assumes the design, checker and receiver model compile first.
`timescale 1ns/1ps
module testbench;
  logic       i_clk_sys = 0, i_reset = 1, wen_n = 1, ld = 1, ren_n = 1, stall = 0;
  logic [8:0] din = 0;
  logic [8:0] ofs [4] = '{9'h002, 9'h040, 9'h005, 9'h040};
  logic [8:0] dflt [4] = '{9'h007, 9'h000, 9'h007, 9'h000};
  wire  [8:0] rd_data;
  wire        rd_valid, rdy, e_n, ae_n, af_n, f_n, dual;
  int         fail_count = 0, n_checks = 0, cnt = 0, n = 7, m = 7;
  always #4 i_clk_sys = ~i_clk_sys;
  sync_fifo_prog_flags i_sync_fifo_prog_flags (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_data(din),
    .i_write_enable_primary_n(wen_n), .i_write_enable_secondary_or_load(ld), .i_read_enable_a_n(ren_n),
    .i_read_enable_b_n(ren_n), .i_rd_ready(rdy), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_empty_flag_n(e_n), .o_almost_empty_flag_n(ae_n), .o_almost_full_flag_n(af_n),
    .o_full_flag_n(f_n), .o_dual_enable_mode(dual));
  rd_sink i_rd_sink (.i_clk_sys(i_clk_sys), .i_stall(stall), .i_valid(rd_valid), .i_data(rd_data), .o_ready(rdy));
  task cmp(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk();
    cmp({e_n, ae_n, af_n, f_n}, {cnt != 0, cnt > n, cnt < 64 - m, cnt != 64});
  endtask
  task rst(input logic mode);
    @(posedge i_clk_sys);
    i_reset <= 1;
    ld <= mode;
    repeat (5) @(posedge i_clk_sys);
    i_reset <= 0;
    ld <= 1;
    cnt = 0;
    #1 chk();
    cmp(9'(dual), 9'(mode));
  endtask
  task wr(input logic [8:0] d, input logic l, input logic w = 0);
    @(posedge i_clk_sys);
    din <= d;
    ld <= l;
    wen_n <= w;
    @(posedge i_clk_sys);
    wen_n <= 1;
    ld <= 1;
    #1;
  endtask
  // reads never share an edge with a write
  task rd(input logic l);
    @(posedge i_clk_sys);
    ld <= l;
    ren_n <= 0;
    @(posedge i_clk_sys);
    ren_n <= 1;
    ld <= 1;
    #1;
  endtask
  task got(input logic [8:0] e);
    @(posedge i_clk_sys);
    #1 cmp(i_rd_sink.q.size() ? i_rd_sink.q.pop_front() : 9'bx, e);
  endtask
  task rd_ofs(input logic [8:0] e [4]);
    for (int k = 0; k < 4; k++) begin
      rd(0);
      got(e[k]);
    end
  endtask
  initial begin
    rst(0);
    rd_ofs(dflt);
    for (int i = 0; i < 8; i++) begin
      wr(9'(i * 5), 1);
      cnt++;
      chk();
    end
    $display("test defaults done");
    for (int k = 0; k < 4; k++) begin
      wr(ofs[k], 0);
      wr(9'h0ff, 0, 1);
    end
    rd_ofs(ofs);
    wr(9'h003, 0);
    n = 3;
    m = 5;
    for (int i = 8; i < 64; i++) begin
      wr(9'(i * 5), 1);
      cnt++;
      chk();
    end
    wr(9'h1ff, 1);
    chk();
    $display("test fill done");
    @(posedge i_clk_sys);
    stall <= 1;
    repeat (3) rd(1);
    cnt = cnt - 2;
    @(posedge i_clk_sys);
    stall <= 0;
    repeat (3) @(posedge i_clk_sys);
    for (int i = 0; i < 64; i++) begin
      if (i > 1) begin
        rd(1);
        cnt--;
      end
      got(9'(i * 5));
      chk();
    end
    rd(1);
    repeat (2) @(posedge i_clk_sys);
    cmp(9'(i_rd_sink.q.size()), 0);
    $display("test drain done");
    rst(1);
    wr(9'h1aa, 0);
    chk();
    wr(9'h1aa, 1);
    cnt++;
    chk();
    rd(0);
    got(9'h1aa);
    cnt--;
    chk();
    $display("test dual done");
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    fail_count++;
    end_of_test();
  end
  task end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
endmodule
